// ### src/battmon_consts.svh
// Constants shared by the device end, the host end and the shared type package.
// Assumes a 10 MHz core clock on both ends.
`ifndef BATTMON_CONSTS_SVH
`define BATTMON_CONSTS_SVH

// Memory function opcodes and page limits
`define OP_WRITE_SP     8'h4e
`define OP_READ_SP      8'hbe
`define OP_COPY_SP      8'h48
`define OP_RECALL       8'hb8
`define OP_CONV_T       8'h44
`define OP_CONV_V       8'hb4
`define PAGE_MAX        8'h07
`define PAGE_BYTES      4'h8
`define READ_LAST_IDX   4'h9

// Status/configuration byte, page 00h byte 0
`define CFG_ICA_BIT     0
`define CFG_CA_BIT      1
`define CFG_EE_BIT      2
`define CFG_AD_BIT      3
`define STAT_TB_BIT     4
`define STAT_NVB_BIT    5
`define STAT_ADB_BIT    6
`define STAT_RSVD_MASK  8'h80
`define CFG_RESET       4'h0

// Page 00h measurement byte positions
`define P0_TEMP_LSB     3'h1
`define P0_TEMP_MSB     3'h2
`define P0_VOLT_LSB     3'h3
`define P0_VOLT_MSB     3'h4
`define P0_CURR_LSB     3'h5
`define P0_CURR_MSB     3'h6

// Timing
`define CLK_KHZ         10000
`define TEMP_CONV_MS    10
`define VOLT_CONV_MS    4
`define COPY_MS         10
`define TEMP_CONV_CYC   (`TEMP_CONV_MS * `CLK_KHZ)
`define VOLT_CONV_CYC   (`VOLT_CONV_MS * `CLK_KHZ)
`define COPY_CYC        (`COPY_MS * `CLK_KHZ)
`define TIMER_W         20

// Host register map (byte addresses) and fields
`define HREG_CTRL       8'h00
`define HREG_WDATA0     8'h04
`define HREG_WDATA1     8'h08
`define HREG_STATUS     8'h0c
`define HREG_RDATA0     8'h10
`define HREG_RDATA1     8'h14
`define HREG_RDATA2     8'h18
`define CTRL_GO_BIT     31
`define CTRL_POLL_BIT   30
`define STATUS_BUSY_BIT 0
`define STATUS_DONE_BIT 1
`define STATUS_POLL_BIT 2

`endif

// ### src/battmon_pkg.sv
// Types shared by both ends of the battery monitor command link.
// Assumes battmon_consts.svh for all numeric constants.
`include "battmon_consts.svh"

package battmon_pkg;

  typedef enum logic [2:0] {ST_CMD, ST_PAGE, ST_WRITE, ST_READ, ST_POLL, ST_WAIT} dev_state_t;
  typedef enum logic [1:0] {POLL_TEMP, POLL_VOLT, POLL_COPY} poll_kind_t;
  typedef enum logic [2:0] {H_IDLE, H_RST, H_OP, H_PAGE, H_WR, H_RD, H_POLL, H_DONE} host_state_t;
  typedef enum logic [2:0] {HOP_WRITE, HOP_READ, HOP_COPY, HOP_RECALL, HOP_CONVT, HOP_CONVV} host_op_t;

  typedef struct packed {
    dev_state_t                  st;
    logic [7:0]                  cmd;
    logic [2:0]                  page;
    logic [3:0]                  idx;
    logic [7:0]                  crc;
    poll_kind_t                  poll;
    logic [3:0]                  cfg;
    logic [`TIMER_W-1:0]         t_cnt;
    logic [`TIMER_W-1:0]         v_cnt;
    logic [`TIMER_W-1:0]         c_cnt;
    logic [2:0]                  c_page;
    logic [7:0][7:0][7:0]        sp;
    logic [7:0][7:0][7:0]        mem;
    logic                        rx_valid;
    logic [7:0]                  rx_data;
    logic                        slot_valid;
    logic                        slot_bit;
  } dev_regs_t;

  typedef struct packed {
    host_state_t                 st;
    host_op_t                    op;
    logic                        poll_en;
    logic [2:0]                  page;
    logic [3:0]                  len;
    logic [3:0]                  cnt;
    logic                        pend;
    logic [63:0]                 wdata;
    logic [71:0]                 rdata;
    logic                        busy;
    logic                        done;
    logic                        poll_ok;
    logic                        ack;
    logic [31:0]                 dat;
    logic                        bus_rst;
    logic                        tx_valid;
    logic [7:0]                  tx_data;
    logic                        rx_req;
    logic                        slot_req;
  } host_regs_t;

  // Check byte, polynomial x^8+x^5+x^4+1, data taken LSB first
  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ data[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// ### src/battmon_link_if.sv
// Byte-level command link between bus master (host) and the battery monitor.
// Assumes both ends share i_mclk; bit slot timing is abstracted away.
`timescale 1ns/100ps

interface battmon_link_if;
  logic       bus_rst;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       rx_req;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       slot_req;
  logic       slot_valid;
  logic       slot_bit;

  modport device (input bus_rst, tx_valid, tx_data, rx_req, slot_req,
                  output rx_valid, rx_data, slot_valid, slot_bit);
  modport host   (output bus_rst, tx_valid, tx_data, rx_req, slot_req,
                  input rx_valid, rx_data, slot_valid, slot_bit);
endinterface // battmon_link_if

// ### src/battmon_device.sv
// Battery monitor memory command unit: scratchpad, memory pages, conversions.
// Assumes the ROM addressing step is done before the first link byte.
// Behaviour
// - Copy opcode copies scratchpad page to memory
// - Nonvolatile busy flag high during copy
// - Read slots give zero until copy done
// - Copy finishes within 10 ms
// - Recall opcode loads memory page into scratchpad
// - Master recalls page before scratchpad read
// - Temperature opcode starts temperature conversion
// - Temperature busy flag high during conversion
// - Read slots give zero until temperature done
// - Temperature conversion within 10 ms
// - Voltage opcode starts conversion, sets busy flag
// - Input select bit chooses voltage source
// - Voltage done clears busy, stores result page 0
// - Other commands accepted during voltage conversion
// - Read slots give zero until voltage done
// - Voltage conversion within 4 ms
// - Scratchpad read yields eight bytes plus check
// - Page 0 byte 0 value 0Fh enables features
// - Master writes opcode, page, data from byte 0
// - Page 0 holds latest measurement results
// - Read starts byte 0, reserved ones, check, ones
// - Write starts byte 0, reset ends it
`timescale 1ns/100ps
`include "battmon_consts.svh"

module battmon_device #(
  parameter int unsigned TEMP_CYCLES = `TEMP_CONV_CYC,
  parameter int unsigned VOLT_CYCLES = `VOLT_CONV_CYC,
  parameter int unsigned COPY_CYCLES = `COPY_CYC
) (
  input  wire logic          i_mclk,
  input  wire logic          i_srst,
  battmon_link_if.device     lnk,
  input  wire logic [15:0]   i_temp_value,
  input  wire logic [15:0]   i_vdd_value,
  input  wire logic [15:0]   i_vad_value,
  input  wire logic [15:0]   i_current_value,
  output logic [3:0]         o_config,
  output logic               o_temperature_busy_flag,
  output logic               o_converter_busy_flag,
  output logic               o_nonvolatile_busy_flag,
  output logic               o_bus_ignored
);

  localparam logic [`TIMER_W-1:0] TEMP_LOAD = TEMP_CYCLES[`TIMER_W-1:0];
  localparam logic [`TIMER_W-1:0] VOLT_LOAD = VOLT_CYCLES[`TIMER_W-1:0];
  localparam logic [`TIMER_W-1:0] COPY_LOAD = COPY_CYCLES[`TIMER_W-1:0];

  battmon_pkg::dev_regs_t r_q;
  battmon_pkg::dev_regs_t r_d;

  logic       tb_flag;
  logic       adb_flag;
  logic       nvb_flag;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;
  logic [15:0] volt_src;

  // ===========================================================
  // Status byte and live flags
  always_comb begin
    tb_flag  = (r_q.t_cnt != '0);
    adb_flag = (r_q.v_cnt != '0);
    nvb_flag = (r_q.c_cnt != '0);
    status_byte = `STAT_RSVD_MASK;
    status_byte[3:0] = r_q.cfg;
    status_byte[`STAT_TB_BIT]  = tb_flag;
    status_byte[`STAT_NVB_BIT] = nvb_flag;
    status_byte[`STAT_ADB_BIT] = adb_flag;
    volt_src = r_q.cfg[`CFG_AD_BIT] ? i_vdd_value : i_vad_value;
    rd_byte = r_q.sp[r_q.page][r_q.idx[2:0]];
    if (r_q.page == 3'h0 && r_q.idx == 4'h0) begin
      rd_byte = rd_byte | `STAT_RSVD_MASK;
    end
  end

  // ===========================================================
  // Next state
  always_comb begin
    r_d = r_q;
    r_d.rx_valid   = 1'b0;
    r_d.slot_valid = 1'b0;

    // Timers run regardless of link state, so commands never wait on them
    if (r_q.t_cnt != '0) begin
      r_d.t_cnt = r_q.t_cnt - 1'b1;
      if (r_q.t_cnt == `TIMER_W'(1)) begin
        r_d.mem[0][`P0_TEMP_LSB] = i_temp_value[7:0];
        r_d.mem[0][`P0_TEMP_MSB] = i_temp_value[15:8];
      end
    end
    if (r_q.v_cnt != '0) begin
      r_d.v_cnt = r_q.v_cnt - 1'b1;
      if (r_q.v_cnt == `TIMER_W'(1)) begin
        r_d.mem[0][`P0_VOLT_LSB] = volt_src[7:0];
        r_d.mem[0][`P0_VOLT_MSB] = volt_src[15:8];
      end
    end
    if (r_q.c_cnt != '0) begin
      r_d.c_cnt = r_q.c_cnt - 1'b1;
      if (r_q.c_cnt == `TIMER_W'(1)) begin
        r_d.mem[r_q.c_page] = r_q.sp[r_q.c_page];
      end
    end
    // Current tracked only while the accumulator is enabled
    if (r_q.cfg[`CFG_ICA_BIT]) begin
      r_d.mem[0][`P0_CURR_LSB] = i_current_value[7:0];
      r_d.mem[0][`P0_CURR_MSB] = i_current_value[15:8];
    end

    if (lnk.bus_rst) begin
      r_d.st  = battmon_pkg::ST_CMD;
      r_d.idx = 4'h0;
    end else begin
      case (r_q.st)
        battmon_pkg::ST_CMD: begin
          // Accepted whatever conversion is still running
          if (lnk.tx_valid) begin
            case (lnk.tx_data)
              `OP_WRITE_SP, `OP_READ_SP, `OP_COPY_SP, `OP_RECALL: begin
                r_d.cmd = lnk.tx_data;
                r_d.st  = battmon_pkg::ST_PAGE;
              end
              `OP_CONV_T: begin
                r_d.t_cnt = TEMP_LOAD;
                r_d.poll  = battmon_pkg::POLL_TEMP;
                r_d.st    = battmon_pkg::ST_POLL;
              end
              `OP_CONV_V: begin
                r_d.v_cnt = VOLT_LOAD;
                r_d.poll  = battmon_pkg::POLL_VOLT;
                r_d.st    = battmon_pkg::ST_POLL;
              end
              default: r_d.st = battmon_pkg::ST_WAIT;
            endcase
          end
        end
        battmon_pkg::ST_PAGE: begin
          if (lnk.tx_valid) begin
            r_d.idx = 4'h0;
            r_d.crc = 8'h00;
            if (lnk.tx_data > `PAGE_MAX) begin
              r_d.st = battmon_pkg::ST_WAIT;
            end else begin
              r_d.page = lnk.tx_data[2:0];
              case (r_q.cmd)
                `OP_WRITE_SP: r_d.st = battmon_pkg::ST_WRITE;
                `OP_READ_SP:  r_d.st = battmon_pkg::ST_READ;
                `OP_COPY_SP: begin
                  r_d.c_cnt  = COPY_LOAD;
                  r_d.c_page = lnk.tx_data[2:0];
                  r_d.poll   = battmon_pkg::POLL_COPY;
                  r_d.st     = battmon_pkg::ST_POLL;
                end
                default: begin
                  r_d.sp[lnk.tx_data[2:0]] = r_q.mem[lnk.tx_data[2:0]];
                  if (lnk.tx_data[2:0] == 3'h0) begin
                    r_d.sp[0][0] = status_byte;
                  end
                  r_d.st = battmon_pkg::ST_WAIT;
                end
              endcase
            end
          end
        end
        battmon_pkg::ST_WRITE: begin
          // Bytes past the end of the page are dropped
          if (lnk.tx_valid && r_q.idx < `PAGE_BYTES) begin
            r_d.sp[r_q.page][r_q.idx[2:0]] = lnk.tx_data;
            if (r_q.page == 3'h0 && r_q.idx == 4'h0) begin
              r_d.cfg = lnk.tx_data[3:0];
            end
            r_d.idx = r_q.idx + 4'h1;
          end
        end
        battmon_pkg::ST_READ: begin
          if (lnk.rx_req) begin
            r_d.rx_valid = 1'b1;
            if (r_q.idx < `PAGE_BYTES) begin
              r_d.rx_data = rd_byte;
              r_d.crc = battmon_pkg::crc8_byte(r_q.crc, rd_byte);
            end else if (r_q.idx == `PAGE_BYTES) begin
              r_d.rx_data = r_q.crc;
            end else begin
              r_d.rx_data = 8'hff;
            end
            if (r_q.idx != `READ_LAST_IDX) begin
              r_d.idx = r_q.idx + 4'h1;
            end
          end
        end
        battmon_pkg::ST_POLL: begin
          if (lnk.slot_req) begin
            r_d.slot_valid = 1'b1;
            case (r_q.poll)
              battmon_pkg::POLL_TEMP: r_d.slot_bit = ~tb_flag;
              battmon_pkg::POLL_VOLT: r_d.slot_bit = ~adb_flag;
              default:                r_d.slot_bit = ~nvb_flag;
            endcase
          end
        end
        default: r_d.st = battmon_pkg::ST_WAIT;
      endcase
    end
  end

  // ===========================================================
  // State register
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      r_q <= '0;
      r_q.st  <= battmon_pkg::ST_CMD;
      r_q.cfg <= `CFG_RESET;
      r_q.rx_data <= 8'hff;
    end else begin
      r_q <= r_d;
    end
  end

  assign lnk.rx_valid   = r_q.rx_valid;
  assign lnk.rx_data    = r_q.rx_data;
  assign lnk.slot_valid = r_q.slot_valid;
  assign lnk.slot_bit   = r_q.slot_bit;

  assign o_config                = r_q.cfg;
  assign o_temperature_busy_flag = tb_flag;
  assign o_converter_busy_flag   = adb_flag;
  assign o_nonvolatile_busy_flag = nvb_flag;
  assign o_bus_ignored           = (r_q.st == battmon_pkg::ST_WAIT);

endmodule // battmon_device

// ### src/battmon_host.sv
// Bus master end: runs one memory function command per software request.
// Assumes a classic Wishbone master on the register side.
`timescale 1ns/100ps
`include "battmon_consts.svh"

module battmon_host (
  input  wire logic          i_mclk,
  input  wire logic          i_srst,
  battmon_link_if.host       lnk,
  input  wire logic          i_wb_cyc,
  input  wire logic          i_wb_stb,
  input  wire logic          i_wb_we,
  input  wire logic [7:0]    i_wb_adr,
  input  wire logic [3:0]    i_wb_sel,
  input  wire logic [31:0]   i_wb_dat,
  output logic [31:0]        o_wb_dat,
  output logic               o_wb_ack
);

  battmon_pkg::host_regs_t r_q;
  battmon_pkg::host_regs_t r_d;
  logic [7:0]  opcode;
  logic        acc;
  logic        wr_take;
  logic [31:0] status;

  always_comb begin
    case (r_q.op)
      battmon_pkg::HOP_WRITE:  opcode = `OP_WRITE_SP;
      battmon_pkg::HOP_READ:   opcode = `OP_READ_SP;
      battmon_pkg::HOP_COPY:   opcode = `OP_COPY_SP;
      battmon_pkg::HOP_RECALL: opcode = `OP_RECALL;
      battmon_pkg::HOP_CONVT:  opcode = `OP_CONV_T;
      default:                 opcode = `OP_CONV_V;
    endcase
    acc = i_wb_cyc & i_wb_stb & ~r_q.ack;
    wr_take = i_wb_cyc & i_wb_stb & i_wb_we & r_q.ack;
    status = 32'h0;
    status[`STATUS_BUSY_BIT] = r_q.busy;
    status[`STATUS_DONE_BIT] = r_q.done;
    status[`STATUS_POLL_BIT] = r_q.poll_ok;
  end

  // ===========================================================
  // Register slave and command sequencer
  always_comb begin
    r_d = r_q;
    r_d.bus_rst  = 1'b0;
    r_d.tx_valid = 1'b0;
    r_d.rx_req   = 1'b0;
    r_d.slot_req = 1'b0;
    r_d.ack      = acc;

    // Writes land at the edge where the master samples ack, so a held request acts once
    if (acc || wr_take) begin
      if (wr_take) begin
        case (i_wb_adr)
          `HREG_CTRL: begin
            // A start while busy is dropped; software polls busy first
            if (i_wb_dat[`CTRL_GO_BIT] && !r_q.busy) begin
              r_d.op      = battmon_pkg::host_op_t'(i_wb_dat[2:0]);
              r_d.page    = i_wb_dat[10:8];
              r_d.len     = i_wb_dat[15:12];
              r_d.poll_en = i_wb_dat[`CTRL_POLL_BIT];
              r_d.busy    = 1'b1;
              r_d.poll_ok = 1'b0;
              r_d.st      = battmon_pkg::H_RST;
            end
          end
          `HREG_WDATA0, `HREG_WDATA1: begin
            for (int b = 0; b < 4; b++) begin
              if (i_wb_sel[b]) begin
                r_d.wdata[(i_wb_adr[3] ? 32 : 0) + b*8 +: 8] = i_wb_dat[b*8 +: 8];
              end
            end
          end
          `HREG_STATUS: begin
            if (i_wb_dat[`STATUS_DONE_BIT]) begin
              r_d.done = 1'b0;
            end
          end
          default: ;
        endcase
      end else if (!i_wb_we) begin
        case (i_wb_adr)
          `HREG_CTRL:   r_d.dat = {16'h0, r_q.len, 1'b0, r_q.page, 5'h0, r_q.op};
          `HREG_WDATA0: r_d.dat = r_q.wdata[31:0];
          `HREG_WDATA1: r_d.dat = r_q.wdata[63:32];
          `HREG_STATUS: r_d.dat = status;
          `HREG_RDATA0: r_d.dat = r_q.rdata[31:0];
          `HREG_RDATA1: r_d.dat = r_q.rdata[63:32];
          `HREG_RDATA2: r_d.dat = {24'h0, r_q.rdata[71:64]};
          default:      r_d.dat = 32'h0;
        endcase
      end
    end

    case (r_q.st)
      battmon_pkg::H_IDLE: ;
      battmon_pkg::H_RST: begin
        r_d.bus_rst = 1'b1;
        r_d.cnt     = 4'h0;
        r_d.pend    = 1'b0;
        r_d.st      = battmon_pkg::H_OP;
      end
      battmon_pkg::H_OP: begin
        r_d.tx_valid = 1'b1;
        r_d.tx_data  = opcode;
        if (r_q.op == battmon_pkg::HOP_CONVT || r_q.op == battmon_pkg::HOP_CONVV) begin
          r_d.st = r_q.poll_en ? battmon_pkg::H_POLL : battmon_pkg::H_DONE;
        end else begin
          r_d.st = battmon_pkg::H_PAGE;
        end
      end
      battmon_pkg::H_PAGE: begin
        r_d.tx_valid = 1'b1;
        r_d.tx_data  = {5'h0, r_q.page};
        case (r_q.op)
          battmon_pkg::HOP_WRITE: r_d.st = (r_q.len == 4'h0) ? battmon_pkg::H_DONE : battmon_pkg::H_WR;
          battmon_pkg::HOP_READ:  r_d.st = (r_q.len == 4'h0) ? battmon_pkg::H_DONE : battmon_pkg::H_RD;
          battmon_pkg::HOP_COPY:  r_d.st = r_q.poll_en ? battmon_pkg::H_POLL : battmon_pkg::H_DONE;
          default:                r_d.st = battmon_pkg::H_DONE;
        endcase
      end
      battmon_pkg::H_WR: begin
        r_d.tx_valid = 1'b1;
        r_d.tx_data  = r_q.wdata[r_q.cnt[2:0]*8 +: 8];
        r_d.cnt      = r_q.cnt + 4'h1;
        if (r_q.cnt + 4'h1 >= r_q.len || r_q.cnt == 4'h7) begin
          r_d.st = battmon_pkg::H_DONE;
        end
      end
      battmon_pkg::H_RD: begin
        if (!r_q.pend) begin
          r_d.rx_req = 1'b1;
          r_d.pend   = 1'b1;
        end else if (lnk.rx_valid) begin
          r_d.rdata[r_q.cnt*8 +: 8] = lnk.rx_data;
          r_d.pend = 1'b0;
          r_d.cnt  = r_q.cnt + 4'h1;
          if (r_q.cnt + 4'h1 >= r_q.len || r_q.cnt == 4'h8) begin
            r_d.st = battmon_pkg::H_DONE;
          end
        end
      end
      battmon_pkg::H_POLL: begin
        // No timeout: the device bounds every conversion and copy
        if (!r_q.pend) begin
          r_d.slot_req = 1'b1;
          r_d.pend     = 1'b1;
        end else if (lnk.slot_valid) begin
          r_d.pend = 1'b0;
          if (lnk.slot_bit) begin
            r_d.poll_ok = 1'b1;
            r_d.st      = battmon_pkg::H_DONE;
          end
        end
      end
      battmon_pkg::H_DONE: begin
        r_d.busy = 1'b0;
        r_d.done = 1'b1;
        r_d.st   = battmon_pkg::H_IDLE;
      end
      default: r_d.st = battmon_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign lnk.bus_rst  = r_q.bus_rst;
  assign lnk.tx_valid = r_q.tx_valid;
  assign lnk.tx_data  = r_q.tx_data;
  assign lnk.rx_req   = r_q.rx_req;
  assign lnk.slot_req = r_q.slot_req;
  assign o_wb_dat     = r_q.dat;
  assign o_wb_ack     = r_q.ack;

endmodule // battmon_host

// ### testbench/battmon_properties.sv
// Link checker: timing of answers and busy/done slots.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
module battmon_properties (
  input wire logic       i_mclk,
  input wire logic       i_srst,
  input wire logic       bus_rst,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       rx_req,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       slot_req,
  input wire logic       slot_valid,
  input wire logic       slot_bit
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  logic done_q;
  // ====================
  // Helpers
  // Done may never fall back to busy before the next bus reset
  always_ff @(posedge i_mclk) begin
    if (i_srst || bus_rst) done_q <= 1'h0;
    else if (slot_valid && slot_bit) done_q <= 1'h1;
  end
  sequence op_s(logic [7:0] op);
    tx_valid && tx_data == op;
  endsequence
  sequence paged_s(logic [7:0] op);
    op_s(op) ##1 tx_valid && tx_data <= 8'h07;
  endsequence
  // ====================
  // Assertions
  rx_answer_a: assert property (rx_req |=> rx_valid) else $error("read byte not answered");
  rx_cause_a: assert property (rx_valid |-> $past(rx_req)) else $error("read byte unasked");
  rx_hold_a: assert property (!rx_valid |-> $stable(rx_data)) else $error("read data moved");
  slot_answer_a: assert property (slot_req |=> slot_valid) else $error("slot not answered");
  slot_done_a: assert property (slot_valid && done_q |-> slot_bit) else $error("done fell back");
  copy_busy_a: assert property (paged_s(8'h48) ##[1:6] slot_req |=> slot_valid && !slot_bit)
    else $error("copy not busy");
  temp_busy_a: assert property (op_s(8'h44) ##[1:6] slot_req |=> slot_valid && !slot_bit)
    else $error("temperature not busy");
  volt_done_a: assert property (op_s(8'hb4) ##[1:6] slot_req |-> ##[1:40] slot_valid && slot_bit)
    else $error("voltage never done");
endmodule // battmon_properties

// ### testbench/battery_monitor_memory_command_unit_tb.sv
// Bench: host and device joined by the link, driven over Wishbone.
// Assumes shortened copy and conversion times.
`timescale 1ns/100ps
module battery_monitor_memory_command_unit_tb;
  logic        i_mclk = 1'h0;
  logic        i_srst = 1'h1;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        we = 1'h0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] rd;
  logic        ack;
  logic [3:0]  cfg;
  logic        tb_f, cb_f, nb_f, ign;
  logic [15:0] temp_v = 16'h1234;
  logic [15:0] vdd_v = 16'h0abc;
  logic [15:0] vad_v = 16'h0555;
  logic [15:0] cur_v = 16'h0ff0;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  localparam logic [63:0] DATA = 64'hfedcba9876543210;
  battmon_link_if battmon_link_if_inst ();
  battmon_device #(.TEMP_CYCLES(20), .VOLT_CYCLES(10), .COPY_CYCLES(20)) battmon_device_inst (
    .i_mclk(i_mclk), .i_srst(i_srst), .lnk(battmon_link_if_inst), .i_temp_value(temp_v),
    .i_vdd_value(vdd_v), .i_vad_value(vad_v), .i_current_value(cur_v), .o_config(cfg),
    .o_temperature_busy_flag(tb_f), .o_converter_busy_flag(cb_f),
    .o_nonvolatile_busy_flag(nb_f), .o_bus_ignored(ign));
  battmon_host battmon_host_inst (
    .i_mclk(i_mclk), .i_srst(i_srst), .lnk(battmon_link_if_inst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rd), .o_wb_ack(ack));
  battmon_properties battmon_properties_inst (
    .i_mclk(i_mclk), .i_srst(i_srst), .bus_rst(battmon_link_if_inst.bus_rst),
    .tx_valid(battmon_link_if_inst.tx_valid), .tx_data(battmon_link_if_inst.tx_data),
    .rx_req(battmon_link_if_inst.rx_req), .rx_valid(battmon_link_if_inst.rx_valid),
    .rx_data(battmon_link_if_inst.rx_data), .slot_req(battmon_link_if_inst.slot_req),
    .slot_valid(battmon_link_if_inst.slot_valid), .slot_bit(battmon_link_if_inst.slot_bit));
  // ====================
  // Clock and timeout
  always #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ====================
  // Shared tasks
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Classic cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge i_mclk); while (ack !== 1'h1);
    q = rd;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic run(input logic [2:0] op, input logic [2:0] pg, input logic [3:0] len, input logic poll,
                     output logic [31:0] st);
    logic [31:0] q;
    wb(1'h1, 8'h00, {1'h1, poll, 14'h0, len, 1'h0, pg, 5'h0, op}, q);
    st = 32'h0;
    while (st[1] !== 1'h1) wb(1'h0, 8'h0c, 32'h0, st);
    wb(1'h1, 8'h0c, 32'h2, q);
  endtask
  task automatic write_page(input logic [2:0] pg, input logic [63:0] d);
    logic [31:0] q;
    wb(1'h1, 8'h04, d[31:0], q);
    wb(1'h1, 8'h08, d[63:32], q);
    run(3'h0, pg, 4'h8, 1'h0, q);
  endtask
  task automatic read_page(input logic [2:0] pg, output logic [71:0] v);
    logic [31:0] a, b, c;
    run(3'h1, pg, 4'h9, 1'h0, a);
    wb(1'h0, 8'h10, 32'h0, a);
    wb(1'h0, 8'h14, 32'h0, b);
    wb(1'h0, 8'h18, 32'h0, c);
    v = {c[7:0], b, a};
  endtask
  function automatic logic [7:0] crc_of(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h0;
    for (int i = 0; i < 64; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    return c;
  endfunction
  // ====================
  // Scenarios
  task automatic s_config();
    logic [31:0] st;
    write_page(3'h0, 64'h0f);
    run(3'h2, 3'h0, 4'h0, 1'h1, st);
    check("copy poll result", st[2], 72'h1);
    check("config bits", cfg, 72'hf);
    check("nonvolatile busy", nb_f, 72'h0);
  endtask
  task automatic s_copy_recall();
    logic [31:0] st;
    logic [71:0] v;
    write_page(3'h3, DATA);
    run(3'h2, 3'h3, 4'h0, 1'h1, st);
    write_page(3'h3, 64'h0);
    run(3'h3, 3'h3, 4'h0, 1'h0, st);
    read_page(3'h3, v);
    check("page 3 with check byte", v, {crc_of(DATA), DATA});
  endtask
  task automatic s_convert();
    logic [31:0] st;
    logic [71:0] v;
    // Unpolled start returns long before the shortened conversion ends
    run(3'h4, 3'h0, 4'h0, 1'h0, st);
    check("temperature busy running", tb_f, 72'h1);
    run(3'h4, 3'h0, 4'h0, 1'h1, st);
    check("temperature poll", st[2], 72'h1);
    check("temperature busy", tb_f, 72'h0);
    run(3'h5, 3'h0, 4'h0, 1'h1, st);
    check("voltage poll", st[2], 72'h1);
    check("converter busy", cb_f, 72'h0);
    run(3'h3, 3'h0, 4'h0, 1'h0, st);
    read_page(3'h0, v);
    check("page 0 results", v[39:0], {vdd_v, temp_v, 8'h8f});
    // Input select cleared: the general input is measured instead of the supply
    write_page(3'h0, 64'h07);
    run(3'h5, 3'h0, 4'h0, 1'h1, st);
    run(3'h3, 3'h0, 4'h0, 1'h0, st);
    read_page(3'h0, v);
    check("page 0 general input", v[39:24], vad_v);
    check("bus ignored", ign, 72'h0);
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    i_srst <= 1'h0;
    s_config();
    s_copy_recall();
    s_convert();
    print_verdict();
  end
endmodule // battery_monitor_memory_command_unit_tb
